/* File: hdl/scs_apb_slave.sv */
// apb decode: zero wait states, pslverr on unmapped address
module scs_apb_slave
    import scs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] rd_slew,
    input  wire logic [31:0] rd_stat,
    input  wire logic [31:0] rd_int,
    input  wire logic [31:0] rd_mask,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    output logic             wr_slew,
    output logic             wr_mask,
    output logic             rd_int_hit,
    output logic [31:0]      wdata
);
    logic access;  // access phase of a transfer
    logic mapped;  // address hits a register
    assign access     = psel & penable;
    assign mapped     = (paddr == SCS_SLEW_CTRL_ADDR) || (paddr == SCS_OSC_STAT_ADDR) ||
                        (paddr == SCS_INT_STAT_ADDR)  || (paddr == SCS_INT_MASK_ADDR);
    assign pready     = 1'b1;
    assign pslverr    = access & ~mapped;
    assign wr_slew    = access & pwrite & (paddr == SCS_SLEW_CTRL_ADDR);
    assign wr_mask    = access & pwrite & (paddr == SCS_INT_MASK_ADDR);
    assign rd_int_hit = access & ~pwrite & (paddr == SCS_INT_STAT_ADDR);
    assign wdata      = pwdata;

    // read mux; unmapped reads return zero
    always_comb begin
        unique case (paddr)
            SCS_SLEW_CTRL_ADDR: prdata = rd_slew;
            SCS_OSC_STAT_ADDR:  prdata = rd_stat;
            SCS_INT_STAT_ADDR:  prdata = rd_int;
            SCS_INT_MASK_ADDR:  prdata = rd_mask;
            default:            prdata = 32'h0000_0000;
        endcase
    end
endmodule : scs_apb_slave

/* File: hdl/scs_clk_div.sv */
// divide-by-n enable generator: pulses once every ratio cycles
module scs_clk_div
    import scs_pkg::*;
#(
    parameter int RATIO_W = 8
) (
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    input  wire logic [RATIO_W-1:0] ratio_m1,   // ratio minus one
    output logic                    tick
);
    if (RATIO_W < 1) begin : g_bad_ratio
        $error("scs_clk_div: RATIO_W too small");
    end
    typedef struct packed {
        logic [RATIO_W-1:0] cnt;
        logic               tick;
    } scs_div_state_t;
    scs_div_state_t st_reg;
    scs_div_state_t st_next;

    // count down; reload on terminal count, or at once when the count exceeds the new ratio
    always_comb begin
        st_next = st_reg;
        if (st_reg.cnt == '0 || st_reg.cnt > ratio_m1) begin
            st_next.cnt  = ratio_m1;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt  = st_reg.cnt - 1'b1;
            st_next.tick = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;
endmodule : scs_clk_div

/* File: hdl/scs_pkg.sv */
package scs_pkg;
    // register byte addresses
    localparam logic [7:0] SCS_SLEW_CTRL_ADDR = 8'h00;  // clock_slew_control
    localparam logic [7:0] SCS_OSC_STAT_ADDR  = 8'h04;  // oscillator_ready_status
    localparam logic [7:0] SCS_INT_STAT_ADDR  = 8'h08;  // sticky events, read clears
    localparam logic [7:0] SCS_INT_MASK_ADDR  = 8'h0C;  // event mask
    // clock_slew_control fields
    localparam int SCS_DIV_LSB   = 16;  // sys_clock_divide 19:16
    localparam int SCS_DIV_W     = 4;
    localparam int SCS_STEP_LSB  = 8;   // slew_step_depth 10:8
    localparam int SCS_STEP_W    = 3;
    localparam int SCS_UPWARD_SLEW_ENABLE_BIT  = 2;
    localparam int SCS_DOWNWARD_SLEW_ENABLE_BIT  = 1;
    localparam int SCS_BUSY_BIT  = 0;
    localparam logic SCS_UPWARD_SLEW_ENABLE_RST = 1'b1;
    localparam logic SCS_DOWNWARD_SLEW_ENABLE_RST = 1'b0;
    // oscillator_ready_status fields
    localparam int SCS_USB_PLL_BIT  = 8;
    localparam int SCS_SYSTEM_PLL_BIT  = 7;
    localparam int SCS_LOW_POWER_RC_OSCILLATOR_BIT  = 5;
    localparam int SCS_SOSC_BIT  = 4;
    localparam int SCS_POSC_BIT  = 2;
    localparam int SCS_FRC_BIT   = 0;
    // interrupt event bits
    localparam int SCS_EV_DONE   = 0;   // slew finished
    localparam int SCS_EV_LOSS   = 1;   // any ready bit fell
    localparam int SCS_EV_W      = 2;
    // step dwell time
    localparam int SCS_CLK_MHZ   = 250;
    localparam int SCS_DWELL_NS  = 64;
    localparam int SCS_DWELL_CYC = (SCS_DWELL_NS * SCS_CLK_MHZ + 999) / 1000;
    localparam int SCS_CNT_W     = 8;
endpackage : scs_pkg

/* File: hdl/scs_slew_ctrl.sv */
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module scs_slew_ctrl
    import scs_pkg::*;
#(
    parameter int DWELL = SCS_DWELL_CYC  // cycles per intermediate step
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // apb register bus
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // oscillator ready levels
    input  wire logic        usb_pll_ready,
    input  wire logic        system_pll_ready,
    input  wire logic        low_power_rc_ready,
    input  wire logic        secondary_osc_ready,
    input  wire logic        primary_osc_ready,
    input  wire logic        fast_rc_ready,
    // switch request from the source logic
    input  wire logic        clk_switch_req,      // source switch request pulse
    input  wire logic        clk_switch_up,       // 1: new source is faster
    // enable, step and interrupt outputs
    output logic             system_clock_en,     // divided system clock enable
    output logic [7:0]       slew_div_log2,       // current intermediate exponent
    output logic             irq
);
    // dwell counts down in 8 bits; zero would wrap and give a 256-cycle step
    if (DWELL < 1 || DWELL > 255) begin : g_bad_dwell
        $error("scs_slew_ctrl: DWELL out of range");
    end

    //////////////////////////////////////////////////////////////////////////
    // state
    // one mode per slew direction
    typedef enum logic [1:0] {SCS_IDLE, SCS_UP, SCS_DOWN} scs_mode_t;
    // block state except divider and enable flop, one record
    typedef struct packed {
        logic [SCS_DIV_W-1:0]  sys_clock_divide;
        logic [SCS_STEP_W-1:0] slew_step_depth;
        logic                  upward_slew_enable;
        logic                  downward_slew_enable;
        logic                  busy;
        scs_mode_t             mode;
        logic [2:0]            cur_exp;       // current step exponent, 0 = none
        logic [SCS_CNT_W-1:0]  dwell;         // cycles left in step
        logic [8:0]            osc_stat;      // ready bits as laid out at 8:0
        logic [SCS_EV_W-1:0]   int_stat;
        logic [SCS_EV_W-1:0]   int_mask;
        logic                  irq;
    } scs_state_t;
    scs_state_t st_reg;
    scs_state_t st_next;

    //////////////////////////////////////////////////////////////////////////
    // bus slave
    // decoder strobes and read words
    logic        wr_slew;     // write strobe, control register
    logic        wr_mask;     // write strobe, mask register
    logic        rd_int_hit;  // read of sticky status, clears it
    logic [31:0] wdata;
    logic [31:0] rd_slew;
    logic [31:0] rd_stat;
    logic [31:0] rd_int;
    logic [31:0] rd_mask;

    // unused positions stay zero because only fields are placed
    always_comb begin
        rd_slew = 32'h0000_0000;
        rd_slew[SCS_DIV_LSB +: SCS_DIV_W]   = st_reg.sys_clock_divide;
        rd_slew[SCS_STEP_LSB +: SCS_STEP_W] = st_reg.slew_step_depth;
        rd_slew[SCS_UPWARD_SLEW_ENABLE_BIT]               = st_reg.upward_slew_enable;
        rd_slew[SCS_DOWNWARD_SLEW_ENABLE_BIT]               = st_reg.downward_slew_enable;
        rd_slew[SCS_BUSY_BIT]               = st_reg.busy;
        // status words padded with zeros
        rd_stat = {23'h00_0000, st_reg.osc_stat};
        rd_int  = {30'h0000_0000, st_reg.int_stat};
        rd_mask = {30'h0000_0000, st_reg.int_mask};
    end

    // zero wait states, no buffering
    scs_apb_slave u_apb (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .rd_slew    (rd_slew),
        .rd_stat    (rd_stat),
        .rd_int     (rd_int),
        .rd_mask    (rd_mask),
        .pready     (pready),
        .pslverr    (pslverr),
        .prdata     (prdata),
        .wr_slew    (wr_slew),
        .wr_mask    (wr_mask),
        .rd_int_hit (rd_int_hit),
        .wdata      (wdata)
    );

    //////////////////////////////////////////////////////////////////////////
    // effective division: slew step while busy, none with both enables clear, else programmed divide
    // a ratio change lands at the next reload, or at once if the count is above it,
    // so lowering the ratio can produce one short period
    logic [7:0] ratio_m1;  // divisor minus one fed to the divider
    always_comb begin
        if (st_reg.busy) begin
            ratio_m1 = 8'((9'h001 << st_reg.cur_exp) - 9'h001);
        end else if (!st_reg.upward_slew_enable && !st_reg.downward_slew_enable) begin
            ratio_m1 = 8'h00;
        end else begin
            ratio_m1 = {4'h0, st_reg.sys_clock_divide};
        end
    end

    // one divider for steps and steady rate
    logic div_tick;  // one pulse per divided period
    scs_clk_div #(.RATIO_W(8)) u_div (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .ratio_m1 (ratio_m1),
        .tick     (div_tick)
    );

    //////////////////////////////////////////////////////////////////////////
    // next state
    // next-state scratch values
    logic [8:0] osc_now;  // ready inputs placed at their bit positions
    logic       slew_ok;  // selected direction may slew
    logic       step_end; // dwell of current step expires
    always_comb begin
        st_next = st_reg;
        osc_now = 9'h000;
        osc_now[SCS_USB_PLL_BIT] = usb_pll_ready;
        osc_now[SCS_SYSTEM_PLL_BIT] = system_pll_ready;
        osc_now[SCS_LOW_POWER_RC_OSCILLATOR_BIT] = low_power_rc_ready;
        osc_now[SCS_SOSC_BIT] = secondary_osc_ready;
        osc_now[SCS_POSC_BIT] = primary_osc_ready;
        osc_now[SCS_FRC_BIT]  = fast_rc_ready;
        // status trails the inputs by a cycle
        st_next.osc_stat = osc_now;
        // only the requested direction counts
        slew_ok  = clk_switch_up ? st_reg.upward_slew_enable : st_reg.downward_slew_enable;
        // last cycle of the current step
        step_end = (st_reg.dwell == 8'h01);

        // read clears sticky status; set below wins
        if (rd_int_hit) begin
            st_next.int_stat = '0;
        end
        // mask write
        if (wr_mask) begin
            st_next.int_mask = wdata[SCS_EV_W-1:0];
        end
        // control writes touch only the writable fields
        if (wr_slew) begin
            st_next.sys_clock_divide     = wdata[SCS_DIV_LSB +: SCS_DIV_W];
            st_next.slew_step_depth      = wdata[SCS_STEP_LSB +: SCS_STEP_W];
            st_next.upward_slew_enable   = wdata[SCS_UPWARD_SLEW_ENABLE_BIT];
            st_next.downward_slew_enable = wdata[SCS_DOWNWARD_SLEW_ENABLE_BIT];
        end

        // slew sequencer
        unique case (st_reg.mode)
            SCS_IDLE: begin
                // depth zero or enable clear: switch directly
                if (clk_switch_req && slew_ok && st_reg.slew_step_depth != 3'h0) begin
                    st_next.busy  = 1'b1;
                    // first step gets a full dwell
                    st_next.dwell = SCS_CNT_W'(DWELL);
                    if (clk_switch_up) begin
                        st_next.mode    = SCS_UP;
                        st_next.cur_exp = st_reg.slew_step_depth;  // largest first
                    end else begin
                        st_next.mode    = SCS_DOWN;
                        st_next.cur_exp = 3'h1;                    // start at divide by 2
                    end
                end
            end
            // requests here are ignored, not queued
            SCS_UP: begin
                st_next.dwell = st_reg.dwell - 1'b1;
                if (step_end) begin
                    st_next.dwell   = SCS_CNT_W'(DWELL);
                    st_next.cur_exp = st_reg.cur_exp - 3'h1;       // halve
                    if (st_reg.cur_exp == 3'h1) begin
                        st_next.mode    = SCS_IDLE;
                        st_next.busy    = 1'b0;                    // final value
                        st_next.cur_exp = 3'h0;
                    end
                end
            end
            // mirror of the upward walk
            SCS_DOWN: begin
                st_next.dwell = st_reg.dwell - 1'b1;
                if (step_end) begin
                    st_next.dwell   = SCS_CNT_W'(DWELL);
                    st_next.cur_exp = st_reg.cur_exp + 3'h1;       // double
                    // >= also ends if depth was lowered mid-slew
                    if (st_reg.cur_exp >= st_reg.slew_step_depth) begin
                        st_next.mode    = SCS_IDLE;
                        st_next.busy    = 1'b0;
                        st_next.cur_exp = 3'h0;
                    end
                end
            end
            // illegal code: back to idle
            default: begin
                st_next.mode = SCS_IDLE;
            end
        endcase

        // sticky events
        // done on the falling edge of busy
        if (st_reg.busy && !st_next.busy) begin
            st_next.int_stat[SCS_EV_DONE] = 1'b1;
        end
        // loss: any ready input dropped
        if ((st_reg.osc_stat & ~osc_now) != 9'h000) begin
            st_next.int_stat[SCS_EV_LOSS] = 1'b1;
        end
        // from next state so it matches the flops
        st_next.irq = |(st_next.int_stat & st_next.int_mask);
    end

    //////////////////////////////////////////////////////////////////////////
    // registers
    // async reset puts the enables at power-on levels
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg                      <= '0;
            st_reg.upward_slew_enable   <= SCS_UPWARD_SLEW_ENABLE_RST;
            st_reg.downward_slew_enable <= SCS_DOWNWARD_SLEW_ENABLE_RST;
            st_reg.mode                 <= SCS_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // divider tick registered so the output is a flop
    // costs one cycle of phase, invisible to software
    logic en_reg;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_reg <= 1'b0;
        end else begin
            en_reg <= div_tick;
        end
    end
    // outputs straight from flops
    assign system_clock_en = en_reg;
    assign slew_div_log2   = {5'h00, st_reg.cur_exp};
    assign irq             = st_reg.irq;

    //////////////////////////////////////////////////////////////////////////
    // assertions
    // sequencer, divider, register and irq checks; the bus side is judged by the bench
    a_busy_mode: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg.busy == (st_reg.mode != SCS_IDLE)) else $error("busy disagrees with mode");

    a_up_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg.mode == SCS_IDLE && clk_switch_req && clk_switch_up && st_reg.upward_slew_enable
        && st_reg.slew_step_depth != 3'h0 |=> st_reg.cur_exp == $past(st_reg.slew_step_depth))
        else $error("upward slew did not start at largest divisor");

    a_down_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg.mode == SCS_IDLE && clk_switch_req && !clk_switch_up && st_reg.downward_slew_enable
        && st_reg.slew_step_depth != 3'h0 |=> st_reg.mode == SCS_DOWN && st_reg.cur_exp == 3'h1)
        else $error("downward slew did not start at divide by 2");

    a_no_up_slew: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg.mode == SCS_IDLE && clk_switch_req && clk_switch_up && !st_reg.upward_slew_enable
        |=> !st_reg.busy) else $error("slewed with upward enable clear");

    a_no_dn_slew: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg.mode == SCS_IDLE && clk_switch_req && !clk_switch_up && !st_reg.downward_slew_enable
        |=> !st_reg.busy) else $error("slewed with downward enable clear");

    a_step_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg.busy && $changed(st_reg.cur_exp) |=> $stable(st_reg.cur_exp) && st_reg.busy)
        else $error("step not held");

    a_div_bypass: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !st_reg.busy && !st_reg.upward_slew_enable && !st_reg.downward_slew_enable
        |-> ratio_m1 == 8'h00) else $error("divide field not ignored");

    a_div_value: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !st_reg.busy && st_reg.upward_slew_enable |-> ratio_m1 == {4'h0, st_reg.sys_clock_divide})
        else $error("divide ratio wrong");

    a_osc_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ##1 rd_stat[SCS_USB_PLL_BIT] == $past(usb_pll_ready) && rd_stat[SCS_FRC_BIT] == $past(fast_rc_ready))
        else $error("ready status not tracking");

    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rd_slew[31:20] == 12'h000 && rd_slew[15:11] == 5'h00 && rd_stat[31:9] == 23'h00_0000)
        else $error("reserved bits not zero");

    a_busy_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg.mode == SCS_IDLE && clk_switch_req && slew_ok && st_reg.slew_step_depth != 3'h0
        |=> st_reg.busy) else $error("busy not set at slew start");

    a_up_descend: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg.mode == SCS_UP && step_end && st_reg.cur_exp != 3'h1
        |=> st_reg.cur_exp == $past(st_reg.cur_exp) - 3'h1) else $error("upward step did not halve");

    a_dwell_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg.busy |-> st_reg.dwell != '0 && st_reg.dwell <= SCS_CNT_W'(DWELL))
        else $error("dwell counter out of range");

    a_done_event: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(st_reg.busy) |-> st_reg.int_stat[SCS_EV_DONE]) else $error("slew end not recorded");

    a_irq_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_reg.irq == |(st_reg.int_stat & st_reg.int_mask)) else $error("irq does not follow status");

    // main scenario covers
    c_up_slew:   cover property (@(posedge sys_clk) st_reg.mode == SCS_UP && st_next.mode == SCS_IDLE);
    c_down_slew: cover property (@(posedge sys_clk) st_reg.mode == SCS_DOWN && st_next.mode == SCS_IDLE);
    c_irq:       cover property (@(posedge sys_clk) st_reg.irq);
    c_deep_step: cover property (@(posedge sys_clk) st_reg.busy && st_reg.cur_exp == 3'h7);
endmodule : scs_slew_ctrl

/* File: test/scs_slew_ctrl_tb_top.sv */
module scs_slew_ctrl_tb_top
    import scs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    //////////////////////////////////////////////////////////////////////////
    localparam int DW = 2;            // short dwell keeps slew runs brief
    logic        sys_clk, sys_rst;    // clock and reset
    logic        psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready, pslverr;
    logic [31:0] prdata;
    logic [5:0]  osc_rdy;             // usb, sys pll, low_power_rc_oscillator, sosc, posc, frc
    logic        clk_switch_req, clk_switch_up;
    logic        system_clock_en, irq;
    logic [7:0]  slew_div_log2;
    int          errors, checks;      // mismatch and comparison counters
    //////////////////////////////////////////////////////////////////////////
    scs_slew_ctrl #(.DWELL(DW)) DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .usb_pll_ready(osc_rdy[5]), .system_pll_ready(osc_rdy[4]), .low_power_rc_ready(osc_rdy[3]),
        .secondary_osc_ready(osc_rdy[2]), .primary_osc_ready(osc_rdy[1]), .fast_rc_ready(osc_rdy[0]),
        .clk_switch_req(clk_switch_req), .clk_switch_up(clk_switch_up),
        .system_clock_en(system_clock_en), .slew_div_log2(slew_div_log2), .irq(irq)
    );
    // free running 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    // one comparison, four-state exact
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // apb transfer: request held until pready is seen high at an edge
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] rd, output logic err);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // completing edge: write lands, read data taken, read clears
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) begin
                rd  = prdata;
                err = pslverr;
                break;
            end
        end
        if (n == 20) begin
            errors++;
            wrap_up();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb_xfer(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb_xfer(1'b0, a, 32'h0, r, e);
        check(name, exp, r);
    endtask : rd_chk
    // count enable pulses over 32 cycles, idle only
    task automatic count_en(input string name, input int exp);
        int c;
        c = 0;
        repeat (8) @(posedge sys_clk);
        repeat (32) begin
            @(posedge sys_clk);
            #1;
            if (system_clock_en === 1'b1) c++;
        end
        check(name, exp, c);
    endtask : count_en
    // one switch request; collects the exponent sequence while stepping
    task automatic slew_run(input logic up, input int k, input logic en);
        logic [31:0] w;
        logic [7:0]  seen[$];
        int          j, n;
        w = 32'h0;
        w[10:8] = k[2:0];
        w[SCS_UPWARD_SLEW_ENABLE_BIT] = up & en;
        w[SCS_DOWNWARD_SLEW_ENABLE_BIT] = ~up & en;
        wr(SCS_SLEW_CTRL_ADDR, w);
        clk_switch_req <= 1'b1;
        clk_switch_up  <= up;
        @(posedge sys_clk);
        clk_switch_req <= 1'b0;
        for (j = 0; j < 1000; j++) begin
            #1;
            if (slew_div_log2 !== 8'h00) seen.push_back(slew_div_log2);
            else if (seen.size() > 0 || j > 4) break;
            @(posedge sys_clk);
        end
        if (j == 1000) begin
            errors++;
            wrap_up();
        end
        n = (en && k > 0) ? k * DW : 0;
        check("step count", n, seen.size());
        for (j = 0; j < seen.size() && j < n; j++) begin
            if (seen[j] !== (up ? 8'(k - j / DW) : 8'(1 + j / DW))) begin
                check("step exponent", up ? 8'(k - j / DW) : 8'(1 + j / DW), seen[j]);
                break;
            end
        end
    endtask : slew_run
    //////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk("ctrl reset", SCS_SLEW_CTRL_ADDR, 32'h0000_0004);
        rd_chk("osc reset", SCS_OSC_STAT_ADDR, 32'h0000_0000);
        rd_chk("mask reset", SCS_INT_MASK_ADDR, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_fields();
        logic [31:0] r;
        logic        e;
        wr(SCS_SLEW_CTRL_ADDR, 32'hFFFF_FFFF);
        rd_chk("ctrl ones", SCS_SLEW_CTRL_ADDR, 32'h000F_0706);
        wr(SCS_SLEW_CTRL_ADDR, 32'h0000_0000);
        rd_chk("ctrl zero", SCS_SLEW_CTRL_ADDR, 32'h0000_0000);
        wr(SCS_OSC_STAT_ADDR, 32'hFFFF_FFFF);
        rd_chk("osc ro", SCS_OSC_STAT_ADDR, 32'h0000_0000);
        apb_xfer(1'b0, 8'h10, 32'h0, r, e);
        check("unmapped err", 32'h1, {31'h0, e});
        $display("test fields done");
    endtask : t_fields
    task automatic t_osc();
        int pos[6] = '{SCS_FRC_BIT, SCS_POSC_BIT, SCS_SOSC_BIT, SCS_LOW_POWER_RC_OSCILLATOR_BIT, SCS_SYSTEM_PLL_BIT, SCS_USB_PLL_BIT};
        for (int i = 0; i < 6; i++) begin
            osc_rdy <= 6'h01 << i;
            repeat (2) @(posedge sys_clk);
            rd_chk("osc bit", SCS_OSC_STAT_ADDR, 32'h1 << pos[i]);
        end
        osc_rdy <= 6'h00;
        repeat (2) @(posedge sys_clk);
        rd_chk("loss event", SCS_INT_STAT_ADDR, 32'h0000_0002);
        rd_chk("read clears", SCS_INT_STAT_ADDR, 32'h0000_0000);
        $display("test osc done");
    endtask : t_osc
    task automatic t_div();
        wr(SCS_SLEW_CTRL_ADDR, 32'h000F_0000);
        count_en("div ignored", 32);
        wr(SCS_SLEW_CTRL_ADDR, 32'h0003_0004);
        count_en("div by 4", 8);
        wr(SCS_SLEW_CTRL_ADDR, 32'h000F_0002);
        count_en("div by 16", 2);
        $display("test div done");
    endtask : t_div
    task automatic t_slew();
        for (int k = 0; k < 8; k++) begin
            slew_run(1'b1, k, 1'b1);
            slew_run(1'b0, k, 1'b1);
        end
        slew_run(1'b1, 3, 1'b0);
        slew_run(1'b0, 3, 1'b0);
        rd_chk("done sticky", SCS_INT_STAT_ADDR, 32'h0000_0001);
        $display("test slew done");
    endtask : t_slew
    task automatic t_busy_irq();
        wr(SCS_INT_MASK_ADDR, 32'h0000_0001);
        wr(SCS_SLEW_CTRL_ADDR, 32'h0000_0704);
        clk_switch_req <= 1'b1;
        clk_switch_up  <= 1'b1;
        @(posedge sys_clk);
        clk_switch_req <= 1'b0;
        rd_chk("busy set", SCS_SLEW_CTRL_ADDR, 32'h0000_0705);
        repeat (7 * DW + 4) @(posedge sys_clk);
        rd_chk("busy clear", SCS_SLEW_CTRL_ADDR, 32'h0000_0704);
        #1;
        check("irq high", 32'h1, {31'h0, irq});
        rd_chk("done event", SCS_INT_STAT_ADDR, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        #1;
        check("irq low", 32'h0, {31'h0, irq});
        wr(SCS_INT_MASK_ADDR, 32'h0000_0000);
        slew_run(1'b1, 1, 1'b1);
        repeat (3) @(posedge sys_clk);
        #1;
        check("irq masked", 32'h0, {31'h0, irq});
        rd_chk("masked sticky", SCS_INT_STAT_ADDR, 32'h0000_0001);
        $display("test busy irq done");
    endtask : t_busy_irq
    //////////////////////////////////////////////////////////////////////////
    // main sequence: everything driven at time zero, reset held 4 cycles
    initial begin
        errors = 0;
        checks = 0;
        sys_rst = 1'b1;
        {psel, penable, pwrite, clk_switch_req, clk_switch_up} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        osc_rdy = 6'h00;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_fields();
        t_osc();
        t_div();
        t_slew();
        t_busy_irq();
        wrap_up();
    end
endmodule : scs_slew_ctrl_tb_top
